// File: rtl/lib_regs.vh
// Register map, field positions, reset values and timing for the LPC to ISA bridge.
`ifndef LIB_REGS_VH
`define LIB_REGS_VH

`define LIB_OFF_CFG      8'h00
`define LIB_OFF_BLKEN    8'h04
`define LIB_OFF_IRQEN    8'h08
`define LIB_OFF_RNGEN    8'h0c
`define LIB_OFF_STAT     8'h10

`define LIB_CFG_WIDE     0
`define LIB_ST_LPC_BUSY  0
`define LIB_ST_ISA_BUSY  1
`define LIB_ST_WIDE_MISS 2
`define LIB_ST_DROPPED   3

`define LIB_CFG_RST      1'b0
`define LIB_BLKEN_RST    4'hf
`define LIB_IRQEN_RST    16'h0000
`define LIB_RNGEN_RST    13'h1002
`define LIB_IRQ_AVAIL    16'h9ef8

`define LIB_WIN_BASE_HI  16'hffd0
`define LIB_ISA_MEM_SEG  4'hd
`define LIB_IO_SEG       4'h0

`define LIB_LPC_START    4'h0
`define LIB_LPC_READY    4'h0
`define LIB_LPC_LWAIT    4'h6
`define LIB_LPC_IDLE     4'hf

`define LIB_MCLK_MHZ     40
`define LIB_CMD_NS       250

`endif

// File: rtl/lib_isa_cycle.v
// ISA bus cycle sequencer: address latch, command strobe, ready stretch and data capture.
`timescale 1ns/1ps
`default_nettype none
module lib_isa_cycle #(
	parameter CMD_CYC = 10
) (
	input  wire        mclk,
	input  wire        reset_n,
	input  wire        start,
	input  wire        is_mem,
	input  wire        wr,
	input  wire        wide,
	input  wire [19:0] addr,
	input  wire [7:0]  wdata,
	input  wire        rdy,
	input  wire [15:0] sd_in,
	output reg  [19:0] sa,
	output reg         sbhe_n,
	output reg         bale,
	output reg         ior_n,
	output reg         iow_n,
	output reg         memr_n,
	output reg         memw_n,
	output reg  [15:0] sd_out,
	output reg         sd_oe,
	output reg         done,
	output reg  [7:0]  rdata,
	output reg         busy
);

	// ----------------------------------------
	// Cycle sequencer
	// ----------------------------------------
	localparam C_IDLE = 2'd0;
	localparam C_ADDR = 2'd1;
	localparam C_CMD  = 2'd2;
	localparam C_END  = 2'd3;

	reg [1:0] st_q;
	reg [7:0] cnt_q;
	reg       mem_q;
	reg       wr_q;
	reg       wide_q;

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_q   <= C_IDLE;
			cnt_q  <= 8'h00;
			mem_q  <= 1'b0;
			wr_q   <= 1'b0;
			wide_q <= 1'b0;
			sa     <= 20'h00000;
			sbhe_n <= 1'b1;
			bale   <= 1'b0;
			ior_n  <= 1'b1;
			iow_n  <= 1'b1;
			memr_n <= 1'b1;
			memw_n <= 1'b1;
			sd_out <= 16'h0000;
			sd_oe  <= 1'b0;
			done   <= 1'b0;
			rdata  <= 8'h00;
			busy   <= 1'b0;
		end else begin
			done <= 1'b0;
			case (st_q)
			C_IDLE: begin
				if (start) begin
					mem_q  <= is_mem;
					wr_q   <= wr;
					wide_q <= wide;
					sa     <= addr;
					// A byte to an odd address rides the high lane of a wide cycle.
					sbhe_n <= ~(wide & addr[0]);
					sd_out <= {wdata, wdata};
					bale   <= 1'b1;
					busy   <= 1'b1;
					st_q   <= C_ADDR;
				end
			end
			C_ADDR: begin
				bale   <= 1'b0;
				sd_oe  <= wr_q;
				ior_n  <= ~(~mem_q & ~wr_q);
				iow_n  <= ~(~mem_q & wr_q);
				memr_n <= ~(mem_q & ~wr_q);
				memw_n <= ~(mem_q & wr_q);
				cnt_q  <= CMD_CYC[7:0] - 8'h01;
				st_q   <= C_CMD;
			end
			C_CMD: begin
				if (cnt_q != 8'h00) begin
					cnt_q <= cnt_q - 8'h01;
				end else if (rdy) begin
					// A slow module holds the strobe by pulling ready low.
					rdata  <= (wide_q & sa[0]) ? sd_in[15:8] : sd_in[7:0];
					ior_n  <= 1'b1;
					iow_n  <= 1'b1;
					memr_n <= 1'b1;
					memw_n <= 1'b1;
					st_q   <= C_END;
				end
			end
			default: begin
				sd_oe <= 1'b0;
				done  <= 1'b1;
				busy  <= 1'b0;
				st_q  <= C_IDLE;
			end
			endcase
		end
	end

endmodule
`default_nettype wire

// File: rtl/lib_bridge.v
// LPC target with APB configuration that forwards I/O and windowed memory cycles to ISA.
//
// Overview of operation
// - Host LPC accesses become ISA bus cycles.
// - I/O cycles are 8-bit unless wide enabled.
// - Wide enabled: every I/O cycle is 16-bit.
// - Forward I/O only in enabled supported ranges.
// - No ISA cycles for conventional memory addresses.
// - Window at 0xFFD00000 maps to segment 0xD000.
// - Four 16 KB block enables, all set.
// - ISA memory cycles are always 8-bit.
// - Accept only available and enabled IRQ lines.
// - Each enabled IRQ line routed exclusively.
// - No DMA channels, no bus mastering grants.
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "lib_regs.vh"
module lib_bridge (
	input  wire        mclk,
	input  wire        reset_n,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        lpc_frame_n,
	input  wire [3:0]  lpc_ad_in,
	output reg  [3:0]  lpc_ad_out,
	output reg         lpc_ad_oe,
	output wire [19:0] isa_sa,
	output wire        isa_sbhe_n,
	output wire        isa_bale,
	output wire        isa_ior_n,
	output wire        isa_iow_n,
	output wire        isa_memr_n,
	output wire        isa_memw_n,
	input  wire [15:0] isa_sd_in,
	output wire [15:0] isa_sd_out,
	output wire        isa_sd_oe,
	input  wire        isa_chrdy,
	input  wire        isa_iocs16_n,
	input  wire [15:0] isa_irq_in,
	output reg  [15:0] host_irq,
	output reg  [7:0]  isa_dack_n,
	output reg         isa_aen
);

	// ----------------------------------------
	// Constants and decode helpers
	// ----------------------------------------
	localparam integer CMD_CYC = (`LIB_CMD_NS * `LIB_MCLK_MHZ + 999) / 1000;
	localparam S_IDLE = 4'd0;
	localparam S_CYC  = 4'd1;
	localparam S_ADDR = 4'd2;
	localparam S_WDAT = 4'd3;
	localparam S_TAR  = 4'd4;
	localparam S_WAIT = 4'd5;
	localparam S_RDAT = 4'd6;
	localparam S_TURN = 4'd7;
	localparam S_END  = 4'd8;

	// One bit per supported I/O range, lowest range first.
	function [12:0] io_hit;
		input [15:0] a;
		begin
			io_hit[0]  = (a == 16'h0080);
			io_hit[1]  = (a >= 16'h0100) && (a <= 16'h01cf);
			io_hit[2]  = (a >= 16'h01d0) && (a <= 16'h01df);
			io_hit[3]  = (a >= 16'h0200) && (a <= 16'h02e7);
			io_hit[4]  = (a >= 16'h02e8) && (a <= 16'h02ef);
			io_hit[5]  = (a >= 16'h02f0) && (a <= 16'h02f7);
			io_hit[6]  = (a >= 16'h02f8) && (a <= 16'h02ff);
			io_hit[7]  = (a >= 16'h0300) && (a <= 16'h0377);
			io_hit[8]  = (a >= 16'h0378) && (a <= 16'h03e7);
			io_hit[9]  = (a >= 16'h03e8) && (a <= 16'h03ef);
			io_hit[10] = (a >= 16'h03f0) && (a <= 16'h03f7);
			io_hit[11] = (a >= 16'h03f8) && (a <= 16'h03ff);
			io_hit[12] = (a >= 16'h0400) && (a <= 16'h0aff);
		end
	endfunction

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	// All LPC and ISA input pins share one two-stage chain; read data are caught two edges old, still in the strobe.
	localparam [38:0] SYNC_RST = {1'b1, `LIB_LPC_IDLE, 1'b1, 1'b1, 16'h0000, 16'h0000};
	reg [38:0] sync_m_q;
	reg [38:0] sync_s_q;

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sync_m_q <= SYNC_RST;
			sync_s_q <= SYNC_RST;
		end else begin
			sync_m_q <= {lpc_frame_n, lpc_ad_in, isa_chrdy, isa_iocs16_n,
				isa_irq_in, isa_sd_in};
			sync_s_q <= sync_m_q;
		end
	end
	wire        frame_s_q = sync_s_q[38];
	wire [3:0]  ad_s_q    = sync_s_q[37:34];
	wire        rdy_s_q   = sync_s_q[33];
	wire        cs16_s_q  = sync_s_q[32];
	wire [15:0] irq_s_q   = sync_s_q[31:16];
	wire [15:0] sd_s_q    = sync_s_q[15:0];

	// ----------------------------------------
	// Configuration registers on APB
	// ----------------------------------------
	reg        wide_cycle_enable_q;
	reg [3:0]  isa_window_block_enable_reg_q;
	reg [15:0] irqen_q;
	reg [12:0] rngen_q;
	reg        wide_miss_q;
	reg        dropped_q;
	reg [3:0]  st_q;
	wire       isa_busy;
	wire       isa_done;
	wire [7:0] isa_rdata;
	wire       set_miss;
	wire       set_drop;
	wire apb_wr = psel & penable & pwrite & pready;
	wire stat_wr = apb_wr & (paddr == `LIB_OFF_STAT);
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			wide_cycle_enable_q           <= `LIB_CFG_RST;
			isa_window_block_enable_reg_q <= `LIB_BLKEN_RST;
			irqen_q     <= `LIB_IRQEN_RST;
			rngen_q     <= `LIB_RNGEN_RST;
			wide_miss_q <= 1'b0;
			dropped_q   <= 1'b0;
		end else begin
			// Read data are caught in the setup cycle so that they leave a flip-flop.
			pready  <= psel & ~penable;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
			if (psel & ~penable) begin
				case (paddr)
				`LIB_OFF_CFG:   prdata <= {31'h0, wide_cycle_enable_q};
				`LIB_OFF_BLKEN: prdata <= {28'h0, isa_window_block_enable_reg_q};
				`LIB_OFF_IRQEN: prdata <= {16'h0, irqen_q};
				`LIB_OFF_RNGEN: prdata <= {19'h0, rngen_q};
				`LIB_OFF_STAT:  prdata <= {28'h0, dropped_q, wide_miss_q, isa_busy,
					(st_q != S_IDLE)};
				default:        pslverr <= 1'b1;
				endcase
			end
			if (apb_wr) begin
				case (paddr)
				`LIB_OFF_CFG:   wide_cycle_enable_q <= pwdata[`LIB_CFG_WIDE];
				`LIB_OFF_BLKEN: isa_window_block_enable_reg_q <= pwdata[3:0];
				`LIB_OFF_IRQEN: irqen_q <= pwdata[15:0] & `LIB_IRQ_AVAIL;
				`LIB_OFF_RNGEN: rngen_q <= pwdata[12:0];
				default: ;
				endcase
			end
			// A new event in the clearing cycle keeps its flag.
			wide_miss_q <= set_miss |
				(wide_miss_q & ~(stat_wr & pwdata[`LIB_ST_WIDE_MISS]));
			dropped_q <= set_drop |
				(dropped_q & ~(stat_wr & pwdata[`LIB_ST_DROPPED]));
		end
	end

	// ----------------------------------------
	// Interrupts, DMA and bus ownership
	// ----------------------------------------
	// Each line drives only its own host input, so no two sources ever share one.
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			host_irq   <= 16'h0000;
			isa_dack_n <= 8'hff;
			isa_aen    <= 1'b0;
		end else begin
			host_irq   <= irq_s_q & irqen_q & `LIB_IRQ_AVAIL;
			// Requests for DMA or mastership are never answered.
			isa_dack_n <= 8'hff;
			isa_aen    <= 1'b0;
		end
	end

	// ----------------------------------------
	// LPC target sequencer
	// ----------------------------------------
	reg [2:0]  cnt_q;
	reg        is_mem_q;
	reg        wr_q;
	reg [31:0] addr_q;
	reg [7:0]  wdat_q;
	reg [7:0]  rdat_q;
	reg        isa_start_q;
	reg        wide_q;
	// Only the relocated window is decoded, so low memory addresses never reach ISA.
	wire in_win = (addr_q[31:16] == `LIB_WIN_BASE_HI);
	wire blk_on = isa_window_block_enable_reg_q[addr_q[15:14]];
	wire io_on  = |(io_hit(addr_q[15:0]) & rngen_q);
	wire fwd    = is_mem_q ? (in_win & blk_on) : io_on;
	wire [19:0] isa_addr = is_mem_q ? {`LIB_ISA_MEM_SEG, addr_q[15:0]}
		: {`LIB_IO_SEG, addr_q[15:0]};

	assign set_miss = isa_done & wide_q & cs16_s_q;
	assign set_drop = (st_q == S_TAR) & (cnt_q == 3'd0) & frame_s_q & ~fwd;

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_q        <= S_IDLE;
			cnt_q       <= 3'd0;
			is_mem_q    <= 1'b0;
			wr_q        <= 1'b0;
			addr_q      <= 32'h00000000;
			wdat_q      <= 8'h00;
			rdat_q      <= 8'h00;
			isa_start_q <= 1'b0;
			wide_q      <= 1'b0;
			lpc_ad_out  <= `LIB_LPC_IDLE;
			lpc_ad_oe   <= 1'b0;
		end else begin
			isa_start_q <= 1'b0;
			if (!frame_s_q) begin
				// Frame low restarts decoding; it also aborts a cycle in progress.
				lpc_ad_oe <= 1'b0;
				st_q <= (ad_s_q == `LIB_LPC_START) ? S_CYC : S_IDLE;
			end else begin
				case (st_q)
				S_IDLE: ;
				S_CYC: begin
					is_mem_q <= ad_s_q[2];
					wr_q     <= ad_s_q[1];
					cnt_q    <= ad_s_q[2] ? 3'd7 : 3'd3;
					addr_q   <= 32'h00000000;
					st_q     <= ad_s_q[3] ? S_IDLE : S_ADDR;
				end
				S_ADDR: begin
					addr_q <= {addr_q[27:0], ad_s_q};
					cnt_q  <= cnt_q - 3'd1;
					if (cnt_q == 3'd0) begin
						cnt_q <= 3'd1;
						st_q  <= wr_q ? S_WDAT : S_TAR;
					end
				end
				S_WDAT: begin
					wdat_q <= {ad_s_q, wdat_q[7:4]};
					cnt_q  <= cnt_q - 3'd1;
					if (cnt_q == 3'd0) begin
						cnt_q <= 3'd1;
						st_q  <= S_TAR;
					end
				end
				S_TAR: begin
					cnt_q <= cnt_q - 3'd1;
					if (cnt_q == 3'd0) begin
						lpc_ad_oe <= 1'b1;
						cnt_q     <= 3'd1;
						if (fwd) begin
							lpc_ad_out  <= `LIB_LPC_LWAIT;
							isa_start_q <= 1'b1;
							// Memory stays 8-bit; I/O width follows the enable alone.
							wide_q <= ~is_mem_q & wide_cycle_enable_q;
							st_q   <= S_WAIT;
						end else begin
							lpc_ad_out <= `LIB_LPC_READY;
							rdat_q     <= 8'hff;
							st_q       <= wr_q ? S_TURN : S_RDAT;
						end
					end
				end
				S_WAIT: begin
					if (isa_done) begin
						lpc_ad_out <= `LIB_LPC_READY;
						rdat_q     <= isa_rdata;
						st_q       <= wr_q ? S_TURN : S_RDAT;
					end
				end
				S_RDAT: begin
					lpc_ad_out <= (cnt_q != 3'd0) ? rdat_q[3:0] : rdat_q[7:4];
					cnt_q      <= cnt_q - 3'd1;
					if (cnt_q == 3'd0) begin
						st_q <= S_TURN;
					end
				end
				S_TURN: begin
					lpc_ad_out <= `LIB_LPC_IDLE;
					st_q       <= S_END;
				end
				default: begin
					lpc_ad_oe <= 1'b0;
					st_q      <= S_IDLE;
				end
				endcase
			end
		end
	end

	// ----------------------------------------
	// ISA cycle engine
	// ----------------------------------------
	lib_isa_cycle #(
		.CMD_CYC (CMD_CYC)
	) u_cycle (
		.mclk    (mclk),
		.reset_n (reset_n),
		.start   (isa_start_q),
		.is_mem  (is_mem_q),
		.wr      (wr_q),
		.wide    (wide_q),
		.addr    (isa_addr),
		.wdata   (wdat_q),
		.rdy     (rdy_s_q),
		.sd_in   (sd_s_q),
		.sa      (isa_sa),
		.sbhe_n  (isa_sbhe_n),
		.bale    (isa_bale),
		.ior_n   (isa_ior_n),
		.iow_n   (isa_iow_n),
		.memr_n  (isa_memr_n),
		.memw_n  (isa_memw_n),
		.sd_out  (isa_sd_out),
		.sd_oe   (isa_sd_oe),
		.done    (isa_done),
		.rdata   (isa_rdata),
		.busy    (isa_busy)
	);

endmodule
`default_nettype wire

// File: testbench/lib_bridge_props.sv
// Checker of the bridge's ISA strobes, interrupt routing and bus ownership pins.
`timescale 1ns/1ps
`default_nettype none
module lib_props (
	input wire logic        mclk,
	input wire logic        reset_n,
	input wire logic [19:0] isa_sa,
	input wire logic        isa_sbhe_n,
	input wire logic        isa_bale,
	input wire logic        isa_ior_n,
	input wire logic        isa_iow_n,
	input wire logic        isa_memr_n,
	input wire logic        isa_memw_n,
	input wire logic        isa_sd_oe,
	input wire logic [15:0] host_irq,
	input wire logic [7:0]  isa_dack_n,
	input wire logic        isa_aen
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	wire io_on  = !isa_ior_n || !isa_iow_n;
	wire mem_on = !isa_memr_n || !isa_memw_n;
	a_no_dma: assert property (isa_dack_n == 8'hff && !isa_aen)
		else $error("dma or ownership pin moved");
	a_irq_avail: assert property ((host_irq & ~16'h9ef8) == 16'h0000)
		else $error("unavailable irq routed");
	a_mem_narrow: assert property (mem_on |-> isa_sbhe_n)
		else $error("wide memory cycle");
	a_mem_seg: assert property ($rose(mem_on) |-> isa_sa[19:16] == 4'hd)
		else $error("memory cycle outside window segment");
	a_io_seg: assert property ($rose(io_on) |-> isa_sa[19:16] == 4'h0)
		else $error("io cycle with high address bits");
	a_bale_cmd: assert property (isa_bale |=> io_on || mem_on)
		else $error("no command after address latch");
	a_cmd_hold: assert property ($rose(io_on || mem_on) |-> (io_on || mem_on) [*8])
		else $error("command strobe too short");
	a_wide_odd: assert property (!isa_sbhe_n |-> isa_sa[0] && !mem_on)
		else $error("high byte enable on even or memory cycle");
	a_read_no_drive: assert property ((!isa_ior_n || !isa_memr_n) |-> !isa_sd_oe)
		else $error("data bus driven during a read");
	cover property ($rose(mem_on));
	cover property (!isa_sbhe_n && io_on);
	cover property (host_irq != 16'h0000);
endmodule
bind lib_bridge lib_props u_props (.mclk, .reset_n, .isa_sa, .isa_sbhe_n, .isa_bale,
	.isa_ior_n, .isa_iow_n, .isa_memr_n, .isa_memw_n, .isa_sd_oe, .host_irq, .isa_dack_n,
	.isa_aen);
`default_nettype wire

// File: testbench/lib_isa_model.sv
// Behavioural ISA expansion module that answers I/O and memory cycles.
`timescale 1ns/1ps
`default_nettype none
module lib_isa_model (
	input  wire logic        mclk,
	input  wire logic        slow,
	input  wire logic        cs16,
	input  wire logic [19:0] isa_sa,
	input  wire logic        isa_sbhe_n,
	input  wire logic        isa_bale,
	input  wire logic        isa_ior_n,
	input  wire logic        isa_iow_n,
	input  wire logic        isa_memr_n,
	input  wire logic        isa_memw_n,
	input  wire logic [15:0] isa_sd_out,
	input  wire logic        isa_sd_oe,
	output wire logic        isa_chrdy,
	output wire logic        isa_iocs16_n,
	output var  logic [15:0] isa_sd_in,
	output var  logic [7:0]  n_cyc,
	output var  logic [19:0] lsa,
	output var  logic        lsbhe,
	output var  logic [7:0]  lwd
);
	wire        rd = !isa_ior_n || !isa_memr_n;
	wire        on = rd || !isa_iow_n || !isa_memw_n;
	// A write byte counts only when both lanes carry it and the bus is driven.
	wire        lanes_ok = isa_sd_oe && (isa_sd_out[15:8] == isa_sd_out[7:0]);
	logic [3:0] w = 4'h0;
	initial n_cyc = 8'h00;
	initial isa_sd_in = 16'h0f0f;
	// Off-cycle data toggles, so a late capture never reads a stale byte.
	always @(posedge mclk) begin
		w <= on ? w + {3'h0, w != 4'hf} : 4'h0;
		isa_sd_in <= rd ? {~isa_sa[7:0], isa_sa[7:0] ^ 8'h5a} : ~isa_sd_in;
		if (isa_bale) begin
			n_cyc <= n_cyc + 8'h01;
			lsa <= isa_sa;
			lsbhe <= isa_sbhe_n;
		end
		if (!isa_iow_n || !isa_memw_n) lwd <= lanes_ok ? isa_sd_out[7:0] : 8'h00;
	end
	assign isa_chrdy = !(slow && on && w < 4'hc);
	assign isa_iocs16_n = !(cs16 && (!isa_ior_n || !isa_iow_n));
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the LPC to ISA bridge.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        mclk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, lpc_frame_n = 1'b1, h_oe = 1'b0, slow = 1'b0;
	logic        cs16 = 1'b0, rerr, lsbhe, pready, pslverr, lpc_ad_oe, isa_sbhe_n;
	logic        isa_bale, isa_ior_n, isa_iow_n, isa_memr_n, isa_memw_n, isa_sd_oe;
	logic        isa_chrdy, isa_iocs16_n, isa_aen;
	logic [7:0]  paddr = 8'h00, isa_dack_n, n_cyc, lwd, rb;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic [3:0]  h_ad = 4'hf, lpc_ad_out;
	logic [15:0] isa_irq_in = 16'h0, host_irq, isa_sd_in, isa_sd_out;
	logic [19:0] isa_sa, lsa;
	wire  [3:0]  lad = lpc_ad_oe ? lpc_ad_out : (h_oe ? h_ad : 4'hf);
	int          num_errors = 0, tests_run = 0, cyc = 0;
	lib_bridge uut (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .lpc_frame_n, .lpc_ad_in(lad), .lpc_ad_out, .lpc_ad_oe, .isa_sa,
		.isa_sbhe_n, .isa_bale, .isa_ior_n, .isa_iow_n, .isa_memr_n, .isa_memw_n, .isa_sd_in,
		.isa_sd_out, .isa_sd_oe, .isa_chrdy, .isa_iocs16_n, .isa_irq_in, .host_irq,
		.isa_dack_n, .isa_aen);
	lib_isa_model isa (.mclk, .slow, .cs16, .isa_sa, .isa_sbhe_n, .isa_bale, .isa_ior_n,
		.isa_iow_n, .isa_memr_n, .isa_memw_n, .isa_sd_out, .isa_sd_oe, .isa_chrdy, .isa_iocs16_n,
		.isa_sd_in, .n_cyc, .lsa, .lsbhe, .lwd);
	always #12.5 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			conclude;
		end
	end
	task automatic conclude;
		if (num_errors == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Host side of one LPC transfer; the wire idles high through its pull-ups.
	task automatic lpc(input logic [3:0] ct, input logic [31:0] a, input logic [7:0] wd);
		int k;
		@(posedge mclk);
		lpc_frame_n <= 1'b0;
		h_oe <= 1'b1;
		h_ad <= 4'h0;
		@(posedge mclk);
		lpc_frame_n <= 1'b1;
		h_ad <= ct;
		for (k = ct[2] ? 7 : 3; k >= 0; k--) begin
			@(posedge mclk);
			h_ad <= a[k*4 +: 4];
		end
		if (ct[1]) begin
			@(posedge mclk);
			h_ad <= wd[3:0];
			@(posedge mclk);
			h_ad <= wd[7:4];
		end
		@(posedge mclk);
		h_ad <= 4'hf;
		@(posedge mclk);
		h_oe <= 1'b0;
		do begin
			@(negedge mclk);
		end while (!(lpc_ad_oe === 1'b1 && lpc_ad_out === 4'h0));
		@(negedge mclk);
		rb[3:0] = lpc_ad_out;
		@(negedge mclk);
		rb[7:4] = lpc_ad_out;
		while (lpc_ad_oe !== 1'b0) @(negedge mclk);
	endtask
	task automatic fwd(input logic [3:0] ct, input logic [31:0] a, input logic [19:0] s,
		input logic hb, input logic [7:0] e);
		logic [7:0] n;
		n = n_cyc;
		lpc(ct, a, 8'h3c);
		chk("isa cycles", n + 8'h01, n_cyc);
		chk("isa addr", s, lsa);
		chk("byte high enable", hb, lsbhe);
		if (ct[1]) chk("isa wdata", 8'h3c, lwd);
		else chk("lpc rdata", e, rb);
	endtask
	task automatic drop(input logic [3:0] ct, input logic [31:0] a);
		logic [7:0] n;
		n = n_cyc;
		lpc(ct, a, 8'h3c);
		chk("isa cycles", n, n_cyc);
		if (!ct[1]) chk("lpc rdata", 8'hff, rb);
	endtask
	task automatic t_regs;
		apb(1'b0, 8'h00, 32'h0);
		chk("wide enable", 32'h0, rdat);
		apb(1'b0, 8'h04, 32'h0);
		chk("block enables", 32'hf, rdat);
		apb(1'b1, 8'h08, 32'hffffffff);
		apb(1'b0, 8'h08, 32'h0);
		chk("irq enables", 32'h9ef8, rdat);
		apb(1'b0, 8'h0c, 32'h0);
		chk("range enables", 32'h1002, rdat);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped error", 32'h1, rerr);
	endtask
	task automatic t_io;
		fwd(4'h2, 32'h123, 20'h00123, 1'b1, 8'h00);
		fwd(4'h0, 32'h401, 20'h00401, 1'b1, 8'h5b);
		fwd(4'h0, 32'haff, 20'h00aff, 1'b1, 8'ha5);
		drop(4'h0, 32'h1d0);
		drop(4'h2, 32'hb00);
		drop(4'h0, 32'h0ff);
		apb(1'b0, 8'h10, 32'h0);
		chk("dropped flag", 32'h8, rdat);
		apb(1'b1, 8'h10, 32'h8);
		apb(1'b1, 8'h0c, 32'h1006);
		apb(1'b0, 8'h10, 32'h0);
		chk("flags cleared", 32'h0, rdat);
		fwd(4'h0, 32'h1d5, 20'h001d5, 1'b1, 8'h8f);
		apb(1'b1, 8'h0c, 32'h1002);
	endtask
	task automatic t_wide;
		apb(1'b1, 8'h00, 32'h1);
		apb(1'b0, 8'h00, 32'h0);
		chk("wide enable", 32'h1, rdat);
		slow <= 1'b1;
		cs16 <= 1'b1;
		fwd(4'h0, 32'h1c3, 20'h001c3, 1'b0, 8'h3c);
		fwd(4'h2, 32'h100, 20'h00100, 1'b1, 8'h00);
		fwd(4'h4, 32'hffd04005, 20'hd4005, 1'b1, 8'h5f);
		slow <= 1'b0;
		cs16 <= 1'b0;
		fwd(4'h0, 32'h402, 20'h00402, 1'b1, 8'h58);
		apb(1'b0, 8'h10, 32'h0);
		chk("wide miss flag", 32'h4, rdat);
		apb(1'b1, 8'h10, 32'h4);
		apb(1'b1, 8'h00, 32'h0);
	endtask
	task automatic t_mem;
		apb(1'b1, 8'h04, 32'hb);
		drop(4'h4, 32'hffd08000);
		fwd(4'h6, 32'hffd0c001, 20'hdc001, 1'b1, 8'h00);
		drop(4'h6, 32'h000d0000);
		fwd(4'h4, 32'hffd0ffff, 20'hdffff, 1'b1, 8'ha5);
		apb(1'b1, 8'h04, 32'hf);
	endtask
	task automatic t_irq;
		@(posedge mclk);
		isa_irq_in <= 16'hffff;
		repeat (5) @(posedge mclk);
		chk("irq all", 32'h9ef8, host_irq);
		apb(1'b1, 8'h08, 32'h10);
		repeat (5) @(posedge mclk);
		chk("irq one", 32'h10, host_irq);
		isa_irq_in <= 16'h0020;
		repeat (5) @(posedge mclk);
		chk("irq masked", 32'h0, host_irq);
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		reset_n <= 1'b1;
		t_regs;
		t_io;
		t_wide;
		t_mem;
		t_irq;
		conclude;
	end
endmodule
`default_nettype wire
